// ### inc/pfpc_pkg.sv
// Package with widths, bit positions and reset values of the pad function and pull-up control.
package pfpc_pkg;

    // ========================================================================
    // Widths
    // ========================================================================
    localparam int PFPC_D_W = 8;
    localparam int PFPC_E_W = 2;
    localparam int PFPC_CS_N = 6;
    localparam int PFPC_SER_N = 4;

    // ========================================================================
    // Bit positions of shared serial pads
    // ========================================================================
    localparam int PFPC_E_SER0_TX = 0;
    localparam int PFPC_E_SER0_RX = 1;
    localparam int PFPC_D_SER1_TX = 6;
    localparam int PFPC_D_SER1_RX = 7;

    // Positions inside the serial pad GPIO select vector.
    localparam int PFPC_SEL_SER0_TX = 0;
    localparam int PFPC_SEL_SER0_RX = 1;
    localparam int PFPC_SEL_SER1_TX = 2;
    localparam int PFPC_SEL_SER1_RX = 3;

    // ========================================================================
    // Reset values
    // ========================================================================
    localparam logic [PFPC_D_W-1:0] PFPC_PUD_RST = 8'hFF;
    localparam logic [PFPC_E_W-1:0] PFPC_PUE_RST = 2'h3;
    localparam logic PFPC_SYS_DIS_RST = 1'h0;
    localparam logic [PFPC_CS_N-1:0] PFPC_CS_SEL_RST = 6'h00;
    localparam logic [PFPC_SER_N-1:0] PFPC_SER_GPIO_RST = 4'h0;
    localparam logic [PFPC_D_W-1:0] PFPC_D_ZERO = 8'h00;
    localparam logic [PFPC_E_W-1:0] PFPC_E_ZERO = 2'h0;

    // Selects one of two pad drive values.
    function automatic logic pfpc_pick(input logic sel, input logic when_set, input logic when_clear);
        pfpc_pick = sel ? when_set : when_clear;
    endfunction

endpackage

// ### inc/pfpc_tap_if.sv
// Interface between the pad control core and the test port pad stage.
interface pfpc_tap_if;

    // ========================================================================
    // Signals
    // ========================================================================
    logic shift;
    logic tdo_data;
    logic tck_rise;
    logic tms_sample;
    logic tdi_sample;
    logic tdo_out;
    logic tdo_oe;

    // The pad stage produces the samples and the output pad drive.
    modport stage (
        input shift,
        input tdo_data,
        output tck_rise,
        output tms_sample,
        output tdi_sample,
        output tdo_out,
        output tdo_oe
    );

    // The core feeds the controller state and reads the samples.
    modport core (
        output shift,
        output tdo_data,
        input tck_rise,
        input tms_sample,
        input tdi_sample,
        input tdo_out,
        input tdo_oe
    );

endinterface

// ### rtl/pfpc_tap_stage.sv
// Test port pad stage: synchronises the test pins, samples on test clock edges and drives test data out.
module pfpc_tap_stage
    import pfpc_pkg::*;
(
    // Clock and reset.
    input wire logic clock,
    input wire logic arst_n,
    // Test pins from the pads.
    input wire logic pad_tck_in,
    input wire logic pad_tms_in,
    input wire logic pad_tdi_in,
    // Link to the core.
    pfpc_tap_if.stage tap
);

    // ========================================================================
    // State
    // ========================================================================
    typedef struct packed {
        logic tck_m;
        logic tck_s;
        logic tck_p;
        logic tms_m;
        logic tms_s;
        logic tdi_m;
        logic tdi_s;
        logic rise;
        logic tms_smp;
        logic tdi_smp;
        logic tdo;
        logic tdo_oe;
    } pfpc_tap_s;

    pfpc_tap_s st_q;
    pfpc_tap_s st_d;

    // Next state: two-stage synchronisers, then edge handling on the settled copies.
    always_comb begin
        st_d = st_q;
        st_d.tck_m = pad_tck_in;
        st_d.tck_s = st_q.tck_m;
        st_d.tck_p = st_q.tck_s;
        st_d.tms_m = pad_tms_in;
        st_d.tms_s = st_q.tms_m;
        st_d.tdi_m = pad_tdi_in;
        st_d.tdi_s = st_q.tdi_m;
        st_d.rise = st_q.tck_s & ~st_q.tck_p;
        // Mode select and data in are taken on the test clock rising edge.
        if (st_q.tck_s && !st_q.tck_p) begin
            st_d.tms_smp = st_q.tms_s;
            st_d.tdi_smp = st_q.tdi_s;
        end
        // Data out and its enable move only on the falling edge, enabled in shift states.
        if (!st_q.tck_s && st_q.tck_p) begin
            st_d.tdo = tap.tdo_data;
            st_d.tdo_oe = tap.shift;
        end
    end

    // State register; the pad is released during reset.
    always_ff @(posedge clock or negedge arst_n) begin
        if (!arst_n) begin
            st_q <= '0;
        end else begin
            st_q <= st_d;
        end
    end

    // Results to the core.
    assign tap.tck_rise = st_q.rise;
    assign tap.tms_sample = st_q.tms_smp;
    assign tap.tdi_sample = st_q.tdi_smp;
    assign tap.tdo_out = st_q.tdo;
    assign tap.tdo_oe = st_q.tdo_oe;

endmodule // pfpc_tap_stage

// ### rtl/pfpc_top.sv
// Pad function and pull-up control for port D, port E, the serial pads and the test port.
module pfpc_top
    import pfpc_pkg::*;
(
    // Clock and reset.
    input wire logic clock,
    input wire logic arst_n,
    // Pull-up control writes and readback.
    input wire logic port_d_pullup_wr,
    input wire logic [PFPC_D_W-1:0] port_d_pullup_wdata,
    input wire logic port_e_pullup_wr,
    input wire logic [PFPC_E_W-1:0] port_e_pullup_wdata,
    input wire logic system_pullup_wr,
    input wire logic system_pullup_wdata,
    output logic [PFPC_D_W-1:0] port_d_pullup_enable,
    output logic [PFPC_E_W-1:0] port_e_pullup_enable,
    output logic system_pullup_disable,
    // Memory interface chip selects.
    input wire logic [PFPC_CS_N-1:0] cs_assign,
    input wire logic [PFPC_CS_N-1:0] cs_n,
    input wire logic mem_bus_active,
    input wire logic idle_bus_drive_bit,
    // Serial pad function select, one bit per pad, set means GPIO.
    input wire logic [PFPC_SER_N-1:0] serial_pad_gpio_sel,
    // Serial channels.
    input wire logic serial_zero_transmit,
    input wire logic serial_one_transmit,
    output logic serial_zero_receive,
    output logic serial_one_receive,
    // GPIO block side.
    input wire logic [PFPC_D_W-1:0] port_d_general_io_out,
    input wire logic [PFPC_D_W-1:0] port_d_general_io_oe,
    input wire logic [PFPC_E_W-1:0] port_e_general_io_out,
    input wire logic [PFPC_E_W-1:0] port_e_general_io_oe,
    output logic [PFPC_D_W-1:0] port_d_general_io_in,
    output logic [PFPC_E_W-1:0] port_e_general_io_in,
    // Port D and port E pads.
    input wire logic [PFPC_D_W-1:0] pad_d_in,
    output logic [PFPC_D_W-1:0] pad_d_out,
    output logic [PFPC_D_W-1:0] pad_d_oe,
    output logic [PFPC_D_W-1:0] pad_d_pu,
    input wire logic [PFPC_E_W-1:0] pad_e_in,
    output logic [PFPC_E_W-1:0] pad_e_out,
    output logic [PFPC_E_W-1:0] pad_e_oe,
    output logic [PFPC_E_W-1:0] pad_e_pu,
    // Test port pads.
    input wire logic pad_tck_in,
    input wire logic pad_tms_in,
    input wire logic pad_tdi_in,
    output logic pad_tdo_out,
    output logic pad_tdo_oe,
    output logic pad_tms_pu,
    output logic pad_tdi_pu,
    // Test controller side.
    input wire logic tap_shift_state,
    input wire logic tap_tdo_data,
    output logic tap_tck_rise,
    output logic tap_tms_sample,
    output logic tap_tdi_sample
);

    // ========================================================================
    // State
    // ========================================================================
    typedef struct packed {
        logic [PFPC_D_W-1:0] d_m;
        logic [PFPC_D_W-1:0] d_s;
        logic [PFPC_E_W-1:0] e_m;
        logic [PFPC_E_W-1:0] e_s;
        logic [PFPC_D_W-1:0] pud;
        logic [PFPC_E_W-1:0] pue;
        logic sys_dis;
        logic tp_pu;
        logic [PFPC_CS_N-1:0] cs_sel;
        logic [PFPC_SER_N-1:0] ser_gpio;
        logic [PFPC_D_W-1:0] d_out;
        logic [PFPC_D_W-1:0] d_oe;
        logic [PFPC_E_W-1:0] e_out;
        logic [PFPC_E_W-1:0] e_oe;
    } pfpc_core_s;

    pfpc_core_s st_q;
    pfpc_core_s st_d;

    // ========================================================================
    // Test port stage
    // ========================================================================
    pfpc_tap_if tap_if ();

    assign tap_if.shift = tap_shift_state;
    assign tap_if.tdo_data = tap_tdo_data;

    pfpc_tap_stage u_tap_stage (
        .clock(clock),
        .arst_n(arst_n),
        .pad_tck_in(pad_tck_in),
        .pad_tms_in(pad_tms_in),
        .pad_tdi_in(pad_tdi_in),
        .tap(tap_if.stage)
    );

    // ========================================================================
    // Next state
    // ========================================================================

    // Synchronisers, pull-up registers, function selects and pad drive.
    always_comb begin
        st_d = st_q;
        st_d.d_m = pad_d_in;
        st_d.d_s = st_q.d_m;
        st_d.e_m = pad_e_in;
        st_d.e_s = st_q.e_m;
        // Software writes to the pull-up control bits.
        if (port_d_pullup_wr) begin
            st_d.pud = port_d_pullup_wdata;
        end
        if (port_e_pullup_wr) begin
            st_d.pue = port_e_pullup_wdata;
        end
        if (system_pullup_wr) begin
            st_d.sys_dis = system_pullup_wdata;
        end
        // Test port pull-ups keep a flop of their own so the pad control leaves a register directly.
        st_d.tp_pu = ~st_d.sys_dis;
        // Chip select assignment follows the memory interface, cleared by reset.
        st_d.cs_sel = cs_assign;
        st_d.ser_gpio = serial_pad_gpio_sel;
        // Default: every pad follows its GPIO driver.
        st_d.d_out = port_d_general_io_out;
        st_d.d_oe = port_d_general_io_oe;
        st_d.e_out = port_e_general_io_out;
        st_d.e_oe = port_e_general_io_oe;
        // Chip select pads drive while the bus is active, or always when idle drive is set.
        for (int i = 0; i < PFPC_CS_N; i++) begin
            st_d.d_out[i] = pfpc_pick(st_q.cs_sel[i], cs_n[i], port_d_general_io_out[i]);
            st_d.d_oe[i] = pfpc_pick(st_q.cs_sel[i], mem_bus_active | idle_bus_drive_bit,
                                     port_d_general_io_oe[i]);
        end
        // Serial one transmit and receive pads on port D.
        st_d.d_out[PFPC_D_SER1_TX] = pfpc_pick(st_q.ser_gpio[PFPC_SEL_SER1_TX],
                                               port_d_general_io_out[PFPC_D_SER1_TX],
                                               serial_one_transmit);
        st_d.d_oe[PFPC_D_SER1_TX] = pfpc_pick(st_q.ser_gpio[PFPC_SEL_SER1_TX],
                                              port_d_general_io_oe[PFPC_D_SER1_TX], 1'h1);
        st_d.d_out[PFPC_D_SER1_RX] = pfpc_pick(st_q.ser_gpio[PFPC_SEL_SER1_RX],
                                               port_d_general_io_out[PFPC_D_SER1_RX], 1'h0);
        st_d.d_oe[PFPC_D_SER1_RX] = pfpc_pick(st_q.ser_gpio[PFPC_SEL_SER1_RX],
                                              port_d_general_io_oe[PFPC_D_SER1_RX], 1'h0);
        // Serial zero transmit and receive pads on port E.
        st_d.e_out[PFPC_E_SER0_TX] = pfpc_pick(st_q.ser_gpio[PFPC_SEL_SER0_TX],
                                               port_e_general_io_out[PFPC_E_SER0_TX],
                                               serial_zero_transmit);
        st_d.e_oe[PFPC_E_SER0_TX] = pfpc_pick(st_q.ser_gpio[PFPC_SEL_SER0_TX],
                                              port_e_general_io_oe[PFPC_E_SER0_TX], 1'h1);
        st_d.e_out[PFPC_E_SER0_RX] = pfpc_pick(st_q.ser_gpio[PFPC_SEL_SER0_RX],
                                               port_e_general_io_out[PFPC_E_SER0_RX], 1'h0);
        st_d.e_oe[PFPC_E_SER0_RX] = pfpc_pick(st_q.ser_gpio[PFPC_SEL_SER0_RX],
                                              port_e_general_io_oe[PFPC_E_SER0_RX], 1'h0);
    end

    // ========================================================================
    // State register
    // ========================================================================

    // Pull-ups come up enabled and every pad comes up undriven.
    always_ff @(posedge clock or negedge arst_n) begin
        if (!arst_n) begin
            st_q.d_m <= PFPC_D_ZERO;
            st_q.d_s <= PFPC_D_ZERO;
            st_q.e_m <= PFPC_E_ZERO;
            st_q.e_s <= PFPC_E_ZERO;
            st_q.pud <= PFPC_PUD_RST;
            st_q.pue <= PFPC_PUE_RST;
            st_q.sys_dis <= PFPC_SYS_DIS_RST;
            st_q.tp_pu <= ~PFPC_SYS_DIS_RST;
            st_q.cs_sel <= PFPC_CS_SEL_RST;
            st_q.ser_gpio <= PFPC_SER_GPIO_RST;
            st_q.d_out <= PFPC_D_ZERO;
            st_q.d_oe <= PFPC_D_ZERO;
            st_q.e_out <= PFPC_E_ZERO;
            st_q.e_oe <= PFPC_E_ZERO;
        end else begin
            st_q <= st_d;
        end
    end

    // ========================================================================
    // Outputs
    // ========================================================================

    // Register readback and pull-up controls.
    assign port_d_pullup_enable = st_q.pud;
    assign port_e_pullup_enable = st_q.pue;
    assign system_pullup_disable = st_q.sys_dis;
    assign pad_d_pu = st_q.pud;
    assign pad_e_pu = st_q.pue;
    assign pad_tms_pu = st_q.tp_pu;
    assign pad_tdi_pu = st_q.tp_pu;

    // Pad drive.
    assign pad_d_out = st_q.d_out;
    assign pad_d_oe = st_q.d_oe;
    assign pad_e_out = st_q.e_out;
    assign pad_e_oe = st_q.e_oe;

    // Synchronised pad levels to GPIO and serial receivers.
    assign port_d_general_io_in = st_q.d_s;
    assign port_e_general_io_in = st_q.e_s;
    assign serial_zero_receive = st_q.e_s[PFPC_E_SER0_RX];
    assign serial_one_receive = st_q.d_s[PFPC_D_SER1_RX];

    // Test port results from the pad stage.
    assign pad_tdo_out = tap_if.tdo_out;
    assign pad_tdo_oe = tap_if.tdo_oe;
    assign tap_tck_rise = tap_if.tck_rise;
    assign tap_tms_sample = tap_if.tms_sample;
    assign tap_tdi_sample = tap_if.tdi_sample;

endmodule // pfpc_top

// ### tb/pfpc_top_asserts.sv
// Concurrent checks of the pad function and pull-up control, bound to the top module.
module pfpc_top_asserts
    import pfpc_pkg::*;
(
    // Clock and reset.
    input wire logic clock,
    input wire logic arst_n,
    // Pull-up control.
    input wire logic port_d_pullup_wr,
    input wire logic [PFPC_D_W-1:0] port_d_pullup_wdata,
    input wire logic port_e_pullup_wr,
    input wire logic [PFPC_E_W-1:0] port_e_pullup_wdata,
    input wire logic [PFPC_D_W-1:0] port_d_pullup_enable,
    input wire logic [PFPC_E_W-1:0] port_e_pullup_enable,
    input wire logic system_pullup_disable,
    input wire logic [PFPC_D_W-1:0] pad_d_pu,
    input wire logic pad_tms_pu,
    input wire logic pad_tdi_pu,
    // Pad function.
    input wire logic [PFPC_CS_N-1:0] cs_assign,
    input wire logic [PFPC_CS_N-1:0] cs_n,
    input wire logic mem_bus_active,
    input wire logic idle_bus_drive_bit,
    input wire logic [PFPC_D_W-1:0] port_d_general_io_out,
    input wire logic [PFPC_D_W-1:0] port_d_general_io_oe,
    input wire logic [PFPC_D_W-1:0] pad_d_out,
    input wire logic [PFPC_D_W-1:0] pad_d_oe,
    input wire logic [PFPC_SER_N-1:0] serial_pad_gpio_sel,
    input wire logic serial_zero_transmit,
    input wire logic serial_zero_receive,
    input wire logic [PFPC_E_W-1:0] pad_e_in,
    input wire logic [PFPC_E_W-1:0] pad_e_out,
    input wire logic [PFPC_E_W-1:0] pad_e_oe,
    // Test port.
    input wire logic pad_tck_in,
    input wire logic pad_tms_in,
    input wire logic pad_tdi_in,
    input wire logic pad_tdo_out,
    input wire logic pad_tdo_oe,
    input wire logic tap_shift_state,
    input wire logic tap_tdo_data,
    input wire logic tap_tck_rise,
    input wire logic tap_tms_sample,
    input wire logic tap_tdi_sample
);
    timeunit 1ns;
    timeprecision 1ns;
    // ========================================================================
    // Assertions
    // ========================================================================
    default clocking cb @(posedge clock); endclocking
    default disable iff (!arst_n);

    // Pull-up loads and their mirror on the pads.
    pud_load_a: assert property (port_d_pullup_wr |=> port_d_pullup_enable == $past(port_d_pullup_wdata))
        else $error("Port D pull-up load wrong.");
    pue_load_a: assert property (port_e_pullup_wr |=> port_e_pullup_enable == $past(port_e_pullup_wdata))
        else $error("Port E pull-up load wrong.");
    pad_pu_a: assert property (pad_d_pu == port_d_pullup_enable && pad_tms_pu == !system_pullup_disable &&
        pad_tdi_pu == !system_pullup_disable) else $error("Pad pull-up differs from its control.");

    // Chip select or GPIO drive of port D pins zero to five.
    for (genvar i = 0; i < PFPC_CS_N; i++) begin : g_cs
        cs_pad_a: assert property ($past(cs_assign[i], 2) && $past(cs_assign[i]) |->
            pad_d_out[i] == $past(cs_n[i]) && pad_d_oe[i] == $past(mem_bus_active | idle_bus_drive_bit))
            else $error("Chip select pad drive wrong.");
        gpio_pad_a: assert property (!$past(cs_assign[i], 2) && !$past(cs_assign[i]) |->
            pad_d_out[i] == $past(port_d_general_io_out[i]) && pad_d_oe[i] == $past(port_d_general_io_oe[i]))
            else $error("GPIO pad drive wrong.");
    end

    // Serial zero pads in their serial function.
    ser_tx_a: assert property ($past(arst_n) && !$past(serial_pad_gpio_sel[0], 2) &&
        !$past(serial_pad_gpio_sel[0]) |-> pad_e_oe[0] && pad_e_out[0] == $past(serial_zero_transmit))
        else $error("Serial transmit pad wrong.");
    ser_rx_a: assert property ($past(arst_n) && !$past(serial_pad_gpio_sel[1], 2) &&
        !$past(serial_pad_gpio_sel[1]) |-> !pad_e_oe[1] && serial_zero_receive == $past(pad_e_in[1], 2))
        else $error("Serial receive pad wrong.");

    // Test clock edges, mode select sampling and test data output timing.
    tck_rise_a: assert property ($rose(pad_tck_in) |-> ##3 tap_tck_rise ##1 !tap_tck_rise)
        else $error("Test clock rise pulse wrong.");
    tms_samp_a: assert property (tap_tck_rise |-> tap_tms_sample == $past(pad_tms_in, 3))
        else $error("Mode select sample wrong.");
    tdi_samp_a: assert property (tap_tck_rise |-> tap_tdi_sample == $past(pad_tdi_in, 3))
        else $error("Data in sample wrong.");
    tdo_hold_a: assert property ($changed(pad_tdo_oe) || $changed(pad_tdo_out) |->
        $past(pad_tck_in, 4) && !$past(pad_tck_in, 3)) else $error("Test data out moved off a fall.");
    tdo_load_a: assert property ($fell(pad_tck_in) |-> ##3 pad_tdo_oe == tap_shift_state &&
        pad_tdo_out == tap_tdo_data) else $error("Test data out not loaded at fall.");
endmodule // pfpc_top_asserts

bind pfpc_top pfpc_top_asserts chk_u (.*);

// ### tb/pfpc_probe_model.sv
// Behavioural test probe that clocks frames into the test port pins.
module pfpc_probe_model (
    // Clock and frame control.
    input wire logic clock,
    input wire logic run,
    // Test pins toward the pads.
    output logic tck,
    output logic tms,
    output logic tdi
);
    timeunit 1ns;
    timeprecision 1ns;
    logic [2:0] cnt_q = 3'h0;

    // Phase counter; eight clocks per test clock period, resting low between frames.
    // Mode select and data in rest at their pulled-up level outside frames.
    always @(negedge clock) begin
        cnt_q <= run ? cnt_q + 3'h1 : 3'h0;
        if (!run) begin
            tms <= 1'b1;
            tdi <= 1'b1;
        end else if (cnt_q == 3'h7) begin
            tms <= 1'($urandom);
            tdi <= 1'($urandom);
        end
    end

    // Mode select only moves with the fall, so it is stable at every rise.
    assign tck = run & cnt_q[2];
endmodule // pfpc_probe_model

// ### tb/tb_top.sv
// Self-checking testbench of the pad function and pull-up control.
module tb_top
    import pfpc_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ns;
`define PFPC_CHK(n, e, a) begin n_checks++; if ((a) !== (e)) begin bad_count++; \
    $display("FAIL %0s exp %h got %h", n, e, a); end end
    logic clock, arst_n, port_d_pullup_wr, port_e_pullup_wr, system_pullup_wr, system_pullup_wdata, run;
    logic [PFPC_D_W-1:0] port_d_pullup_wdata, port_d_pullup_enable, port_d_general_io_out, port_d_general_io_oe;
    logic [PFPC_D_W-1:0] port_d_general_io_in, pad_d_in, pad_d_out, pad_d_oe, pad_d_pu;
    logic [PFPC_E_W-1:0] port_e_pullup_wdata, port_e_pullup_enable, port_e_general_io_out, port_e_general_io_oe;
    logic [PFPC_E_W-1:0] port_e_general_io_in, pad_e_in, pad_e_out, pad_e_oe, pad_e_pu;
    logic [PFPC_CS_N-1:0] cs_assign, cs_n;
    logic [PFPC_SER_N-1:0] serial_pad_gpio_sel;
    logic system_pullup_disable, mem_bus_active, idle_bus_drive_bit, serial_zero_transmit, serial_one_transmit;
    logic serial_zero_receive, serial_one_receive, pad_tck_in, pad_tms_in, pad_tdi_in, pad_tdo_out, pad_tdo_oe;
    logic pad_tms_pu, pad_tdi_pu, tap_shift_state, tap_tdo_data, tap_tck_rise, tap_tms_sample, tap_tdi_sample;
    int bad_count = 0, n_checks = 0, rises = 0;
    typedef struct {int id; logic [7:0] v;} pfpc_note_s;
    pfpc_note_s q[$];
    event look;
    string nm[11] = '{"d_pu", "e_pu", "sys_pu", "d_oe", "d_out", "e_pad", "rx", "d_in", "d_pur", "e_pur", "rises"};

    // ========================================================================
    // Design, probe and clock
    // ========================================================================
    pfpc_top dut_u (.*);
    pfpc_probe_model probe_u (.clock(clock), .run(run), .tck(pad_tck_in), .tms(pad_tms_in), .tdi(pad_tdi_in));
    initial begin
        clock = 1'b0;
        forever #10 clock = ~clock;
    end

    // Test controller state changes only while the test clock is high.
    always @(posedge pad_tck_in) begin
        tap_shift_state <= 1'($urandom);
        tap_tdo_data <= 1'($urandom);
    end

    // Counts rise pulses seen by the test controller side.
    always @(posedge clock) if (tap_tck_rise === 1'b1) rises <= rises + 1;

    // ========================================================================
    // Notes, watcher and verdict
    // ========================================================================
    function automatic logic [7:0] obs(input int id);
        case (id)
            0: obs = pad_d_pu;
            1: obs = {6'h00, pad_e_pu};
            2: obs = {5'h00, pad_tms_pu, pad_tdi_pu, system_pullup_disable};
            3: obs = pad_d_oe;
            4: obs = pad_d_out;
            5: obs = {4'h0, pad_e_oe, pad_e_out};
            6: obs = {4'h0, port_e_general_io_in, serial_one_receive, serial_zero_receive};
            7: obs = port_d_general_io_in;
            8: obs = port_d_pullup_enable;
            9: obs = {6'h00, port_e_pullup_enable};
            default: obs = 8'(rises);
        endcase
    endfunction
    task automatic step(input int k);
        repeat (k) @(negedge clock);
    endtask
    task automatic note(input int id, input logic [7:0] v);
        q.push_back('{id, v});
        -> look;
    endtask
    task automatic report_and_stop();
        $display("Checks %0d, mismatches %0d", n_checks, bad_count);
        if (bad_count == 0 && n_checks > 0) begin
            $display("Finished cleanly");
        end else begin
            $display("Finished with errors");
        end
        $finish;
    endtask

    // Takes every queued note, oldest first, whenever results are announced and compares each.
    always @(look) begin
        pfpc_note_s n;
        while (q.size() > 0) begin
            n = q.pop_front();
            `PFPC_CHK(nm[n.id], n.v, obs(n.id))
        end
    end

    // Cuts a hung run short.
    initial begin
        #50000;
        bad_count++;
        report_and_stop();
    end

    // ========================================================================
    // Main sequence
    // ========================================================================
    initial begin
        logic [7:0] v, eo, ee;
        logic [1:0] fo, fe;
        void'($urandom(32'hECD4));
        {arst_n, run, port_d_pullup_wr, port_e_pullup_wr, system_pullup_wr, system_pullup_wdata, port_d_pullup_wdata,
            port_e_pullup_wdata, cs_assign, cs_n, mem_bus_active, idle_bus_drive_bit, serial_pad_gpio_sel,
            serial_zero_transmit, serial_one_transmit, port_d_general_io_out, port_d_general_io_oe,
            port_e_general_io_out, port_e_general_io_oe, pad_d_in, pad_e_in} = '0;
        step(10);
        note(0, 8'hFF);
        note(1, 8'h03);
        note(2, 8'h06);
        note(8, 8'hFF);
        note(9, 8'h03);
        note(3, 8'h00);
        arst_n = 1'b1;
        step(2);
        // Back-to-back pull-up loads, clearing each port D bit in turn.
        port_d_pullup_wr = 1'b1;
        port_e_pullup_wr = 1'b1;
        for (int n = 0; n < 10; n++) begin
            v = (n < 8) ? ~(8'h01 << n) : 8'($urandom);
            port_d_pullup_wdata = v;
            port_e_pullup_wdata = 2'(n);
            step(1);
            note(8, v);
            note(0, v);
            note(1, {6'h00, 2'(n)});
        end
        {port_d_pullup_wr, port_e_pullup_wr, system_pullup_wr, system_pullup_wdata} = 4'h3;
        step(1);
        note(8, v);
        note(2, 8'h01);
        system_pullup_wdata = 1'b0;
        step(1);
        system_pullup_wr = 1'b0;
        note(2, 8'h06);
        // Pad functions; odd passes use the recommended idle drive setting.
        for (int n = 0; n < 12; n++) begin
            cs_assign = (n == 0) ? 6'h00 : (n < 5) ? 6'h3F : 6'($urandom);
            serial_pad_gpio_sel = (n == 0) ? 4'h0 : 4'($urandom);
            {mem_bus_active, idle_bus_drive_bit} = 2'(n);
            {cs_n, port_d_general_io_out, port_d_general_io_oe, port_e_general_io_out, port_e_general_io_oe} =
                26'($urandom);
            {serial_zero_transmit, serial_one_transmit, pad_d_in, pad_e_in} = 12'($urandom);
            step(3);
            eo = port_d_general_io_out;
            ee = port_d_general_io_oe;
            for (int i = 0; i < PFPC_CS_N; i++) begin
                if (cs_assign[i]) {eo[i], ee[i]} = {cs_n[i], mem_bus_active | idle_bus_drive_bit};
            end
            if (!serial_pad_gpio_sel[2]) {eo[6], ee[6]} = {serial_one_transmit, 1'b1};
            if (!serial_pad_gpio_sel[3]) {eo[7], ee[7]} = 2'b00;
            fo = port_e_general_io_out;
            fe = port_e_general_io_oe;
            if (!serial_pad_gpio_sel[0]) {fo[0], fe[0]} = {serial_zero_transmit, 1'b1};
            if (!serial_pad_gpio_sel[1]) {fo[1], fe[1]} = 2'b00;
            note(3, ee);
            note(4, eo);
            note(5, {4'h0, fe, fo});
            note(7, pad_d_in);
            note(6, {4'h0, pad_e_in, pad_d_in[7], pad_e_in[1]});
        end
        // One test port frame of six test clock periods.
        run <= 1'b1;
        step(48);
        run <= 1'b0;
        step(6);
        note(10, 8'h06);
        step(2);
        report_and_stop();
    end
endmodule // tb_top
